// File: hbfmc_regs.svh
// Timing constants of the H-bridge fault and mode controller
`ifndef HBFMC_REGS_SVH
`define HBFMC_REGS_SVH
`define HBFMC_CLK_NS 40
// Blanking base and step, in ns
`define HBFMC_BLANK_MAX_NS 1800
`define HBFMC_BLANK_STEP_NS 300
`define HBFMC_BLANK_MIN_NS 900
// Deglitch, retry, sleep entry and wake delays, in ns
`define HBFMC_OCP_DEGLITCH_NS 3000
`define HBFMC_RETRY_NS 1600000
`define HBFMC_SLEEP_NS 1000000
`define HBFMC_WAKE_NS 1000000
// Cycle counts, least times rounded up, longest rounded down
`define HBFMC_OCP_CYC ((`HBFMC_OCP_DEGLITCH_NS + `HBFMC_CLK_NS - 1) / `HBFMC_CLK_NS)
`define HBFMC_RETRY_CYC ((`HBFMC_RETRY_NS + `HBFMC_CLK_NS - 1) / `HBFMC_CLK_NS)
`define HBFMC_SLEEP_CYC (`HBFMC_SLEEP_NS / `HBFMC_CLK_NS)
`define HBFMC_WAKE_CYC ((`HBFMC_WAKE_NS + `HBFMC_CLK_NS - 1) / `HBFMC_CLK_NS)
`endif

// File: hbfmc_pkg.sv
// Types of the H-bridge fault and mode controller
package hbfmc_pkg;
   typedef enum logic [1:0] {HBFMC_COAST, HBFMC_FWD, HBFMC_REV, HBFMC_BRAKE}
      hbfmc_drive_t;
   typedef enum logic [1:0] {HBFMC_SLOW, HBFMC_FAST, HBFMC_MIXED, HBFMC_RSV}
      hbfmc_decay_t;
   typedef enum {HBFMC_S_WAKE, HBFMC_S_RUN, HBFMC_S_SLEEPING, HBFMC_S_ASLEEP}
      hbfmc_pwr_t;
endpackage : hbfmc_pkg

// File: hbfmc_bridge.sv
// One bridge: input decode, blanking, overcurrent deglitch and retry
`timescale 1ns/10ps
`default_nettype none
`include "hbfmc_regs.svh"
module hbfmc_bridge (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic in_one,
   input wire logic in_two,
   input wire logic [1:0] torque_scale,
   input wire logic [1:0] ref_band,
   input wire logic run,
   input wire logic ocp_kill,
   input wire logic fet_limit,
   input wire logic sense_over,
   input wire logic chop_trip,
   output logic ocp_fault,
   output logic blank_active,
   output logic chop_allowed,
   output hbfmc_pkg::hbfmc_drive_t drive
);
   import hbfmc_pkg::*;
   localparam int OCP_CYC = `HBFMC_OCP_CYC;
   localparam int RETRY_CYC = `HBFMC_RETRY_CYC;

   // Blanking in cycles for a torque code and reference band (3 = top)
   function automatic logic [5:0] blank_cyc(input logic [1:0] trq,
                                            input logic [1:0] band);
      int ns;
      ns = `HBFMC_BLANK_MAX_NS
         - `HBFMC_BLANK_STEP_NS * (int'(trq) + 3 - int'(band));
      if (ns < `HBFMC_BLANK_MIN_NS)
         ns = `HBFMC_BLANK_MIN_NS;
      blank_cyc = 6'((ns + `HBFMC_CLK_NS - 1) / `HBFMC_CLK_NS);
   endfunction : blank_cyc

   hbfmc_drive_t dec;
   logic [5:0] blank_r, blank_nxt;
   logic [6:0] deg_r, deg_nxt;
   logic [15:0] retry_r, retry_nxt;
   logic hit;
   logic seg;
   hbfmc_drive_t last_r;

   always_comb begin
      case ({in_one, in_two})
         2'b10: dec = HBFMC_FWD;
         2'b01: dec = HBFMC_REV;
         2'b11: dec = HBFMC_BRAKE;
         default: dec = HBFMC_COAST;
      endcase
   end

   assign hit = fet_limit | sense_over;
   assign ocp_fault = (retry_r != 16'h0000);
   assign drive = (run && !ocp_fault && !ocp_kill) ? dec : HBFMC_COAST;
   assign seg = (drive == HBFMC_FWD || drive == HBFMC_REV);
   // A fresh or reversed drive phase is blanked from its first cycle
   assign blank_active = seg && (blank_r != 6'h00 || drive != last_r);
   // Sensing, and chopping with it, waits out the blanking window
   assign chop_allowed = !blank_active && chop_trip && seg;

   always_comb begin
      blank_nxt = blank_r;
      deg_nxt = deg_r;
      retry_nxt = retry_r;
      if (seg && drive == last_r) begin
         if (blank_r != 6'h00)
            blank_nxt = blank_r - 6'h01;
      end else if (seg) begin
         // Direction change restarts the window without a reload gap
         blank_nxt = blank_cyc(torque_scale, ref_band) - 6'h01;
      end else begin
         blank_nxt = blank_cyc(torque_scale, ref_band);
      end
      // Sense pin only trusted outside blanking
      if (run && (fet_limit || (sense_over && !blank_active))) begin
         if (deg_r != 7'(OCP_CYC))
            deg_nxt = deg_r + 7'h01;
      end else begin
         deg_nxt = 7'h00;
      end
      if (retry_r != 16'h0000) begin
         retry_nxt = retry_r - 16'h0001;
      end else if (deg_r == 7'(OCP_CYC) && hit) begin
         retry_nxt = 16'(RETRY_CYC);
         deg_nxt = 7'h00;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         blank_r <= 6'h00;
         deg_r <= 7'h00;
         retry_r <= 16'h0000;
         last_r <= HBFMC_COAST;
      end else begin
         last_r <= drive;
         blank_r <= blank_nxt;
         deg_r <= deg_nxt;
         retry_r <= retry_nxt;
      end
   end

   AST_RETRY_HOLDS: assert property (@(posedge clk_sys) disable iff (!resetn)
      $rose(ocp_fault) |-> ocp_fault [*8])
      else $error("Retry ended too early");
   AST_OCP_OFF: assert property (@(posedge clk_sys) disable iff (!resetn)
      ocp_fault |-> drive == HBFMC_COAST)
      else $error("Bridge driven during overcurrent");
   AST_NO_EARLY_CHOP: assert property (@(posedge clk_sys) disable iff (!resetn)
      $rose(drive == HBFMC_FWD) |-> !chop_allowed [*8])
      else $error("Chop inside blanking");
endmodule : hbfmc_bridge
`default_nettype wire

// File: hbfmc_top.sv
// Fault, sleep and parallel-mode control of a dual H-bridge driver
`timescale 1ns/10ps
`default_nettype none
`include "hbfmc_regs.svh"
// Summary of operation
// - Sense comparator ignored during blanking after drive switches on.
// - Blanking is the shortest drive phase; no earlier chop.
// - Blanking from torque and band: 1.80 us less 0.30 steps, min 0.90.
// - PWM variant: parallel select sampled only at power-up or wake, then held.
// - Parallel mode drives both bridges from bridge A inputs.
// - Parallel mode uses bridge A decay and reference only.
// - Supply undervoltage: bridges and pump off, fault low, regulator on.
// - Supply undervoltage clear: resume first, then release fault.
// - Pump undervoltage: bridges off, fault low, pump stays on.
// - Pump undervoltage clear: resume bridges, then release fault.
// - Current limit past deglitch: affected bridge off, fault low.
// - Sense voltage over threshold also counts as overcurrent.
// - Phase/enable variant: overcurrent on either stops both bridges.
// - PWM variant: only the faulting bridge stops, except that a bridge A fault also stops bridge B in parallel mode.
// - After retry period re-enable and release; repeat while faulted.
// - Overtemperature: bridges off, fault low, pump stays on.
// - Temperature back under hysteresis: resume, then release fault.
// - Sleep low: pump and regulator off, outputs high impedance.
// - Sleep reached within the entry delay after falling edge.
// - No output change until wake delay after sleep input rises.
// - Input pair: coast, forward, reverse, brake with low sides.
module hbfmc_top (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic pwm_variant,
   input wire logic sleep_request_n,
   input wire logic parallel_select,
   input wire logic bridge_a_input_one,
   input wire logic bridge_a_input_two,
   input wire logic bridge_b_input_one,
   input wire logic bridge_b_input_two,
   input wire hbfmc_pkg::hbfmc_decay_t bridge_a_decay_select,
   input wire hbfmc_pkg::hbfmc_decay_t bridge_b_decay_select,
   input wire logic [1:0] bridge_a_current_reference,
   input wire logic [1:0] bridge_b_current_reference,
   input wire logic [1:0] torque_scale,
   input wire logic supply_undervoltage_lockout,
   input wire logic pump_undervoltage,
   input wire logic thermal_shutdown,
   input wire logic [1:0] fet_limit,
   input wire logic [1:0] current_sense_pin,
   input wire logic [1:0] chop_trip,
   output logic fault_indication_n,
   output logic pump_enable,
   output logic regulator_enable,
   output logic asleep,
   output logic parallel_mode,
   output hbfmc_pkg::hbfmc_drive_t bridge_a_drive,
   output hbfmc_pkg::hbfmc_drive_t bridge_b_drive,
   output hbfmc_pkg::hbfmc_decay_t bridge_a_decay,
   output hbfmc_pkg::hbfmc_decay_t bridge_b_decay,
   output logic [1:0] blanking,
   output logic [1:0] chop_start
);
   import hbfmc_pkg::*;
   localparam int SLEEP_CYC = `HBFMC_SLEEP_CYC;
   localparam int WAKE_CYC = `HBFMC_WAKE_CYC;

   hbfmc_pwr_t pwr_r, pwr_nxt;
   logic [15:0] tmr_r, tmr_nxt;
   logic parallel_select_r, parallel_select_nxt;
   logic run;
   logic stop_all;
   logic [1:0] overcurrent_protection, kill, blank_w, chop_w;
   hbfmc_drive_t drv_a, drv_b;
   logic b_one, b_two;
   logic [1:0] ref_b;
   logic fault_n_nxt;
   logic fault_clear_r;
   hbfmc_drive_t a_drv_r, b_drv_r;
   hbfmc_decay_t a_dec_r, b_dec_r;
   logic fault_n_r, pump_r, reg_r, asleep_r;
   logic [1:0] blank_r, chop_r;

   // Power state: wake delay, run, sleep entry, asleep
   always_comb begin
      pwr_nxt = pwr_r;
      tmr_nxt = tmr_r;
      parallel_select_nxt = parallel_select_r;
      case (pwr_r)
         HBFMC_S_WAKE: begin
            if (!sleep_request_n) begin
               pwr_nxt = HBFMC_S_SLEEPING;
               tmr_nxt = 16'(SLEEP_CYC - 3);
            end else if (tmr_r == 16'h0000) begin
               pwr_nxt = HBFMC_S_RUN;
            end else begin
               tmr_nxt = tmr_r - 16'h0001;
            end
         end
         HBFMC_S_RUN: begin
            if (!sleep_request_n) begin
               // Short by the output flop so asleep rises inside the delay
               pwr_nxt = HBFMC_S_SLEEPING;
               tmr_nxt = 16'(SLEEP_CYC - 3);
            end
         end
         HBFMC_S_SLEEPING: begin
            // Entry completes within the sleep delay, rising or not
            if (tmr_r == 16'h0000) begin
               pwr_nxt = HBFMC_S_ASLEEP;
            end else begin
               tmr_nxt = tmr_r - 16'h0001;
            end
         end
         HBFMC_S_ASLEEP: begin
            if (sleep_request_n) begin
               pwr_nxt = HBFMC_S_WAKE;
               tmr_nxt = 16'(WAKE_CYC - 1);
               parallel_select_nxt = parallel_select & pwm_variant;
            end
         end
         default: pwr_nxt = HBFMC_S_ASLEEP;
      endcase
   end

   // Mode latch is loaded at wake only; reset drops into the wake path
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         pwr_r <= HBFMC_S_ASLEEP;
         tmr_r <= 16'h0000;
         parallel_select_r <= 1'b0;
      end else begin
         pwr_r <= pwr_nxt;
         tmr_r <= tmr_nxt;
         parallel_select_r <= parallel_select_nxt;
      end
   end

   assign stop_all = supply_undervoltage_lockout | pump_undervoltage
      | thermal_shutdown;
   assign run = (pwr_r == HBFMC_S_RUN) && !stop_all;

   // Parallel mode feeds bridge A controls to bridge B
   assign b_one = parallel_select_r ? bridge_a_input_one : bridge_b_input_one;
   assign b_two = parallel_select_r ? bridge_a_input_two : bridge_b_input_two;
   assign ref_b = parallel_select_r ? bridge_a_current_reference
      : bridge_b_current_reference;
   // Phase/enable variant stops both on either fault
   assign kill[0] = !pwm_variant && overcurrent_protection[1];
   assign kill[1] = (!pwm_variant || parallel_select_r) && overcurrent_protection[0];

   hbfmc_bridge u_bridge_a (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .in_one(bridge_a_input_one),
      .in_two(bridge_a_input_two),
      .torque_scale(torque_scale),
      .ref_band(bridge_a_current_reference),
      .run(run),
      .ocp_kill(kill[0]),
      .fet_limit(fet_limit[0]),
      .sense_over(current_sense_pin[0]),
      .chop_trip(chop_trip[0]),
      .ocp_fault(overcurrent_protection[0]),
      .blank_active(blank_w[0]),
      .chop_allowed(chop_w[0]),
      .drive(drv_a)
   );

   hbfmc_bridge u_bridge_b (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .in_one(b_one),
      .in_two(b_two),
      .torque_scale(torque_scale),
      .ref_band(ref_b),
      .run(run),
      .ocp_kill(kill[1]),
      .fet_limit(fet_limit[1]),
      .sense_over(current_sense_pin[1]),
      .chop_trip(parallel_select_r ? chop_trip[0] : chop_trip[1]),
      .ocp_fault(overcurrent_protection[1]),
      .blank_active(blank_w[1]),
      .chop_allowed(chop_w[1]),
      .drive(drv_b)
   );

   // Fault pin is released one cycle after the gated drive resumes, so resume first
   assign fault_n_nxt = !(stop_all | overcurrent_protection[0] | overcurrent_protection[1]);

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         a_drv_r <= HBFMC_COAST;
         b_drv_r <= HBFMC_COAST;
         a_dec_r <= HBFMC_SLOW;
         b_dec_r <= HBFMC_SLOW;
         fault_n_r <= 1'b1;
         fault_clear_r <= 1'b1;
         pump_r <= 1'b0;
         reg_r <= 1'b0;
         asleep_r <= 1'b1;
         blank_r <= 2'b00;
         chop_r <= 2'b00;
      end else begin
         a_drv_r <= drv_a;
         b_drv_r <= drv_b;
         a_dec_r <= bridge_a_decay_select;
         b_dec_r <= parallel_select_r ? bridge_a_decay_select
            : bridge_b_decay_select;
         fault_clear_r <= fault_n_nxt;
         // Falls at once, rises a cycle after the drive has resumed
         fault_n_r <= fault_n_nxt && fault_clear_r;
         pump_r <= (pwr_r != HBFMC_S_ASLEEP)
            && !supply_undervoltage_lockout;
         reg_r <= (pwr_r != HBFMC_S_ASLEEP);
         asleep_r <= (pwr_r == HBFMC_S_ASLEEP);
         blank_r <= blank_w;
         chop_r <= chop_w;
      end
   end

   assign fault_indication_n = fault_n_r;
   assign pump_enable = pump_r;
   assign regulator_enable = reg_r;
   assign asleep = asleep_r;
   assign parallel_mode = parallel_select_r;
   assign bridge_a_drive = a_drv_r;
   assign bridge_b_drive = b_drv_r;
   assign bridge_a_decay = a_dec_r;
   assign bridge_b_decay = b_dec_r;
   assign blanking = blank_r;
   assign chop_start = chop_r;

   AST_SUPPLY_UNDERVOLTAGE_LOCKOUT_OFF: assert property (@(posedge clk_sys) disable iff (!resetn)
      supply_undervoltage_lockout && pwr_r != HBFMC_S_ASLEEP |=>
      !pump_enable && regulator_enable
      && bridge_a_drive == HBFMC_COAST && !fault_indication_n)
      else $error("Undervoltage shutdown wrong");
   AST_PUMP_UV: assert property (@(posedge clk_sys) disable iff (!resetn)
      pump_undervoltage && pwr_r == HBFMC_S_RUN |=> pump_enable
      && bridge_b_drive == HBFMC_COAST && !fault_indication_n)
      else $error("Pump undervoltage shutdown wrong");
   AST_THERMAL: assert property (@(posedge clk_sys) disable iff (!resetn)
      thermal_shutdown |=> !fault_indication_n
      && bridge_a_drive == HBFMC_COAST)
      else $error("Thermal shutdown wrong");
   AST_SLEEP_HIZ: assert property (@(posedge clk_sys) disable iff (!resetn)
      pwr_r == HBFMC_S_ASLEEP |=> !regulator_enable && !pump_enable
      && bridge_a_drive == HBFMC_COAST)
      else $error("Sleep outputs not off");
   AST_WAKE_QUIET: assert property (@(posedge clk_sys) disable iff (!resetn)
      $rose(pwr_r == HBFMC_S_WAKE) |-> (bridge_a_drive == HBFMC_COAST) [*8])
      else $error("Output changed before wake delay");
   AST_PARALLEL_SELECT_HOLD: assert property (@(posedge clk_sys) disable iff (!resetn)
      pwr_r != HBFMC_S_ASLEEP |=> $stable(parallel_mode))
      else $error("Parallel mode changed while awake");
   AST_PARALLEL_SELECT_FOLLOW: assert property (@(posedge clk_sys) disable iff (!resetn)
      parallel_mode && !overcurrent_protection[0] && !overcurrent_protection[1] |=>
      bridge_b_drive == $past(drv_a))
      else $error("Bridge B not following A");
   AST_PE_BOTH: assert property (@(posedge clk_sys) disable iff (!resetn)
      !pwm_variant && (overcurrent_protection[0] || overcurrent_protection[1]) |=>
      bridge_a_drive == HBFMC_COAST && bridge_b_drive == HBFMC_COAST)
      else $error("Phase/enable overcurrent not shutting both");
   AST_RESUME_FIRST: assert property (@(posedge clk_sys) disable iff (!resetn)
      $rose(fault_n_nxt) |=> !fault_indication_n ##1 fault_indication_n)
      else $error("Fault release timing wrong");
endmodule : hbfmc_top
`default_nettype wire

// File: hbfmc_host.sv
// Host controller model that drives the bridge control pins
`timescale 1ns/10ps
`default_nettype none
`include "hbfmc_regs.svh"
module hbfmc_host (
   input wire logic clk_sys,
   output logic sleep_request_n,
   output logic [4:0] pins,
   output logic [1:0] torque_scale,
   output logic [1:0] band
);
   // pins: a one, a two, b one, b two, parallel select
   initial begin
      sleep_request_n = 1'b1;
      pins = 5'h00;
      torque_scale = 2'h0;
      band = 2'h3;
   end
   task automatic set_pins(input logic [4:0] v);
      @(negedge clk_sys);
      pins = v;
   endtask : set_pins
   task automatic set_trq(input logic [1:0] t, input logic [1:0] b);
      @(negedge clk_sys);
      torque_scale = t;
      band = b;
   endtask : set_trq
   // Host trusts sleep only once the entry delay has run out
   task automatic go_sleep();
      @(negedge clk_sys);
      sleep_request_n = 1'b0;
      repeat (`HBFMC_SLEEP_CYC) @(negedge clk_sys);
   endtask : go_sleep
endmodule : hbfmc_host
`default_nettype wire

// File: tb_hbfmc_top.sv
// Self-checking testbench of the H-bridge fault and mode controller
`timescale 1ns/10ps
`default_nettype none
`include "hbfmc_regs.svh"
module tb_hbfmc_top;
   import hbfmc_pkg::*;
   logic clk_sys, resetn, sleep_n, fault_n, pump, reg_en, asleep, par;
   logic [4:0] pins;
   logic [2:0] flt;
   logic [1:0] trq, band, fet, sense, trip, blank, chop;
   hbfmc_drive_t drv_a, drv_b;
   hbfmc_decay_t dec_a, dec_b;
   int n_errors = 0;
   int n_checks = 0;
   hbfmc_host hbfmc_host_inst (.clk_sys(clk_sys), .sleep_request_n(sleep_n),
      .pins(pins), .torque_scale(trq), .band(band));
   hbfmc_top hbfmc_top_inst (.clk_sys(clk_sys), .resetn(resetn),
      .pwm_variant(1'b1), .sleep_request_n(sleep_n),
      .parallel_select(pins[4]), .bridge_a_input_one(pins[0]),
      .bridge_a_input_two(pins[1]), .bridge_b_input_one(pins[2]),
      .bridge_b_input_two(pins[3]), .bridge_a_decay_select(HBFMC_SLOW),
      .bridge_b_decay_select(HBFMC_FAST), .bridge_a_current_reference(band),
      .bridge_b_current_reference(band), .torque_scale(trq),
      .supply_undervoltage_lockout(flt[0]), .pump_undervoltage(flt[1]),
      .thermal_shutdown(flt[2]), .fet_limit(fet), .current_sense_pin(sense),
      .chop_trip(trip), .fault_indication_n(fault_n), .pump_enable(pump),
      .regulator_enable(reg_en), .asleep(asleep), .parallel_mode(par),
      .bridge_a_drive(drv_a), .bridge_b_drive(drv_b),
      .bridge_a_decay(dec_a), .bridge_b_decay(dec_b), .blanking(blank),
      .chop_start(chop));
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   task automatic fail(input string m);
      n_errors++;
      $display("FAIL %0t %s", $time, m);
   endtask : fail
   task automatic chk_bit(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) fail("flag mismatch");
   endtask : chk_bit
   task automatic chk_drv(input hbfmc_drive_t got, input hbfmc_drive_t exp);
      n_checks++;
      if (got !== exp) fail("drive mismatch");
   endtask : chk_drv
   task automatic chk_cnt(input int got, input int lo, input int hi);
      n_checks++;
      if (got < lo || got > hi) fail("cycle count out of range");
   endtask : chk_cnt
   task automatic finish_test();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : finish_test
   task automatic t_wake();
      int n;
      n = 0;
      while (drv_a !== HBFMC_FWD && n < 26000) begin
         @(negedge clk_sys);
         n++;
      end
      chk_cnt(n, `HBFMC_WAKE_CYC, `HBFMC_WAKE_CYC + 5);
      chk_bit(par, 1'b0);
      chk_bit(dec_b === HBFMC_FAST, 1'b1);
      chk_bit(dec_a === HBFMC_SLOW, 1'b1);
   endtask : t_wake
   task automatic t_decode();
      // Select goes high mid-run; the latched mode must not follow
      for (int i = 0; i < 4; i++) begin
         hbfmc_host_inst.set_pins({1'b1, 2'(3 - i), 2'(i)});
         repeat (2) @(negedge clk_sys);
         chk_drv(drv_a, hbfmc_drive_t'(i));
         chk_drv(drv_b, hbfmc_drive_t'(3 - i));
         chk_bit(par, 1'b0);
      end
   endtask : t_decode
   task automatic t_blank(input logic [1:0] t, input logic [1:0] b,
      input int exp);
      int n;
      n = 0;
      hbfmc_host_inst.set_trq(t, b);
      hbfmc_host_inst.set_pins(5'h00);
      repeat (3) @(negedge clk_sys);
      hbfmc_host_inst.set_pins(5'h01);
      while (blank[0] !== 1'b1 && n < 10) begin
         @(negedge clk_sys);
         n++;
      end
      trip[0] = 1'b1;
      n = 0;
      while (blank[0] === 1'b1 && n < 100) begin
         n++;
         if (n == exp / 2) chk_bit(chop[0], 1'b0);
         @(negedge clk_sys);
      end
      chk_cnt(n, exp, exp);
      repeat (2) @(negedge clk_sys);
      chk_bit(chop[0], 1'b1);
      trip[0] = 1'b0;
   endtask : t_blank
   task automatic t_faults();
      int n;
      hbfmc_host_inst.set_pins(5'h09);
      for (int k = 0; k < 3; k++) begin
         repeat (3) @(negedge clk_sys);
         flt = 3'(1 << k);
         repeat (2) @(negedge clk_sys);
         chk_bit(fault_n, 1'b0);
         chk_drv(drv_a, HBFMC_COAST);
         chk_drv(drv_b, HBFMC_COAST);
         chk_bit(pump, k != 0);
         chk_bit(reg_en, 1'b1);
         flt = 3'h0;
         n = 0;
         while (drv_a !== HBFMC_FWD && n < 10) begin
            @(negedge clk_sys);
            n++;
         end
         chk_bit(fault_n, 1'b0);
         @(negedge clk_sys);
         chk_bit(fault_n, 1'b1);
      end
   endtask : t_faults
   task automatic t_ocp();
      int n;
      fet[0] = 1'b1;
      repeat (60) @(negedge clk_sys);
      chk_drv(drv_a, HBFMC_FWD);
      repeat (20) @(negedge clk_sys);
      chk_drv(drv_a, HBFMC_COAST);
      chk_bit(fault_n, 1'b0);
      chk_drv(drv_b, HBFMC_REV);
      fet[0] = 1'b0;
      n = 0;
      while (fault_n !== 1'b1 && n < 41000) begin
         @(negedge clk_sys);
         n++;
      end
      chk_cnt(n, `HBFMC_RETRY_CYC - 100, `HBFMC_RETRY_CYC);
      chk_drv(drv_a, HBFMC_FWD);
      sense[1] = 1'b1;
      repeat (80) @(negedge clk_sys);
      chk_drv(drv_b, HBFMC_COAST);
      chk_bit(fault_n, 1'b0);
      chk_drv(drv_a, HBFMC_FWD);
      sense[1] = 1'b0;
   endtask : t_ocp
   task automatic t_sleep();
      hbfmc_host_inst.go_sleep();
      repeat (2) @(negedge clk_sys);
      chk_bit(asleep, 1'b1);
      chk_bit(pump, 1'b0);
      chk_bit(reg_en, 1'b0);
      chk_drv(drv_a, HBFMC_COAST);
   endtask : t_sleep
   initial begin
      resetn = 1'b0;
      flt = 3'h0;
      fet = 2'h0;
      sense = 2'h0;
      trip = 2'h0;
      repeat (10) @(negedge clk_sys);
      chk_bit(fault_n, 1'b1);
      hbfmc_host_inst.set_pins(5'h01);
      resetn = 1'b1;
      t_wake();
      t_decode();
      t_blank(2'h0, 2'h3, 45);
      t_blank(2'h1, 2'h2, 30);
      t_faults();
      t_ocp();
      t_sleep();
      finish_test();
   end
   // Whole run is about 90300 cycles; this cuts a hang short
   initial begin
      repeat (100000) @(posedge clk_sys);
      fail("watchdog expired");
      finish_test();
   end
endmodule : tb_hbfmc_top
`default_nettype wire
